// ---- tio_clkblk.sv ----
// one clock block: a tick enable from the reference or from a pin edge
module tio_clkblk #(
    parameter int                         DIV_W   = 8,
    parameter bit                         FIXED   = 1'b0,
    parameter logic [DIV_W-1:0]           FIX_DIV = 8'h01
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             run,
    input  wire logic             src_pin,
    input  wire logic             pin_lvl,
    input  wire logic [DIV_W-1:0] div,
    output logic                  tick
);
    logic             pin_prev_q;
    logic [DIV_W-1:0] cnt_q;
    logic [DIV_W-1:0] div_eff;
    logic             src_ev;
    logic             active;

    // a zero divider means divide by one
    assign div_eff = FIXED ? FIX_DIV : ((div == '0) ? DIV_W'(1) : div);
    assign active  = FIXED || run;
    // pin source counts rising edges of the external clock
    assign src_ev  = (!FIXED && src_pin) ? (pin_lvl && !pin_prev_q) : 1'b1;
    assign tick    = active && src_ev && (cnt_q == div_eff - 1'b1);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_prev_q <= 1'b0;
        end else begin
            pin_prev_q <= pin_lvl;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (!active) begin
            cnt_q <= '0;
        end else if (src_ev) begin
            cnt_q <= (cnt_q >= div_eff - 1'b1) ? '0 : cnt_q + 1'b1;
        end
    end
endmodule // tio_clkblk

// ---- tio_fifo.sv ----
// small first-word-fall-through fifo with valid/ready on both sides
module tio_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q;
    logic [AW-1:0]    rd_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // tio_fifo

// ---- tio_pin_model.sv ----
// external hardware on the pins: resolves each line and plays far-side drivers
module tio_pin_model (
    input wire logic [31:0] pin_out,
    input wire logic [31:0] pin_oe_n,
    input wire logic [31:0] pin_pd,
    input wire logic [31:0] ext_drv,
    input wire logic [31:0] ext_val,
    input wire logic [4:0]  ext_stb,
    output logic [31:0]     pin_in,
    output logic [4:0]      input_strobe
);
    // ----
    // wire levels
    // ----
    // a floating line shows the inverse of pin_out, or low while the pull-down is on, never a stale match
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_drv & ext_val)
        | (pin_oe_n & ~ext_drv & ~pin_pd & ~pin_out);
    assign input_strobe = ext_stb;
endmodule // tio_pin_model

// ---- tio_pkg.sv ----
// shared constants and types for the timed i/o port bank
package tio_pkg;
    // ------------------------------------------------------------
    // structure
    // ------------------------------------------------------------
    localparam int NPORT       = 5;
    localparam int NCB         = 6;
    localparam int DATA_W      = 32;
    localparam int CNT_W       = 16;
    localparam int FIFO_DEPTH  = 4;
    localparam int PORT_WIDTH [NPORT] = '{1, 4, 8, 16, 32};
    localparam int CLK_PIN     = 0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int SYS_CLK_HZ  = 50_000_000;
    localparam int REF_CLK_HZ  = 100_000_000;
    localparam int REF_DIV     = (SYS_CLK_HZ / REF_CLK_HZ < 1) ? 1 : SYS_CLK_HZ / REF_CLK_HZ;

    // ------------------------------------------------------------
    // port configuration word
    // ------------------------------------------------------------
    localparam int CFG_W        = 10;
    localparam int CFG_EN_BIT   = 0;
    localparam int CFG_OD_BIT   = 1;
    localparam int CFG_DIR_BIT  = 2;
    localparam int CFG_STB_BIT  = 3;
    localparam int CFG_COND_LSB = 4;
    localparam int CFG_CLK_LSB  = 6;
    localparam logic [CFG_W-1:0] PORT_CFG_RST = 10'h000;

    // ------------------------------------------------------------
    // clock block configuration word
    // ------------------------------------------------------------
    localparam int CB_CFG_W   = 10;
    localparam int CB_DIV_W   = 8;
    localparam int CB_SRC_BIT = 8;
    localparam int CB_RUN_BIT = 9;
    localparam logic [CB_CFG_W-1:0] CB_CFG_RST = 10'h201;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_OUT, OP_IN, OP_SETC, OP_SETD, OP_SETPT, OP_GETTS, OP_GETCNT, OP_SETCB
    } tio_op_t;

    typedef enum logic [1:0] {COND_NONE, COND_EQ, COND_NE} tio_cond_t;
endpackage

// ---- tio_port_bank.sv ----
// timed i/o port bank: five ports of 1..32 pins sharing 32 pins, six clock blocks
module tio_port_bank (
    input  wire logic                   sys_clk,
    input  wire logic                   rst_n,
    input  wire logic                   cpu_req,
    input  wire tio_pkg::tio_op_t       cpu_op,
    input  wire logic [2:0]             cpu_sel,
    input  wire logic [31:0]            cpu_wdata,
    output logic                        cpu_ready,
    output logic [31:0]                 cpu_rdata,
    output logic                        cpu_rvalid,
    input  wire logic [31:0]            link_pin_en,
    input  wire logic [31:0]            pin_in,
    output logic [31:0]                 pin_out,
    output logic [31:0]                 pin_oe_n,
    output logic [31:0]                 pin_pd,
    input  wire logic [4:0]             input_strobe,
    output logic [4:0]                  output_strobe,
    output logic [4:0]                  sched_event
);
    localparam int NP = tio_pkg::NPORT;
    localparam int NC = tio_pkg::NCB;
    localparam int DW = tio_pkg::DATA_W;
    localparam int CW = tio_pkg::CNT_W;

    // ------------------------------------------------------------
    // per-port views gathered for the pin mux and readback
    // ------------------------------------------------------------
    logic [DW-1:0] p_drv   [NP];
    logic [DW-1:0] p_xfer  [NP];
    logic [CW-1:0] p_cnt   [NP];
    logic [CW-1:0] p_ts    [NP];
    logic [NP-1:0] p_en;
    logic [NP-1:0] p_od;
    logic [NP-1:0] p_dir;
    logic [NP-1:0] p_full;
    logic [NP-1:0] p_fifo_rdy;
    logic [NC-1:0] cb_tick;
    logic          accept;
    logic          sel_port;
    logic [31:0]   pin_out_d;
    logic [31:0]   pin_oe_n_d;

    assign sel_port = (cpu_sel < 3'(NP));
    assign accept   = cpu_req && cpu_ready;

    // never stalls except output into a full fifo or input with no word yet
    always_comb begin
        cpu_ready = 1'b1;
        if (sel_port) begin
            case (cpu_op)
                tio_pkg::OP_OUT: cpu_ready = p_fifo_rdy[cpu_sel];
                tio_pkg::OP_IN:  cpu_ready = p_full[cpu_sel];
                default:         cpu_ready = 1'b1;
            endcase
        end
    end

    // ------------------------------------------------------------
    // clock blocks
    // ------------------------------------------------------------
    for (genvar c = 0; c < NC; c++) begin : g_cb
        logic [tio_pkg::CB_CFG_W-1:0] cfg_q;

        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                cfg_q <= tio_pkg::CB_CFG_RST;
            end else if (accept && cpu_op == tio_pkg::OP_SETCB && cpu_sel == 3'(c)) begin
                cfg_q <= cpu_wdata[tio_pkg::CB_CFG_W-1:0];
            end
        end

        // block 0 ticks every cycle (REF_DIV clamps to 1, half the reference rate) and ignores its config
        tio_clkblk #(
            .DIV_W   (tio_pkg::CB_DIV_W),
            .FIXED   (c == 0),
            .FIX_DIV (tio_pkg::CB_DIV_W'(tio_pkg::REF_DIV))
        ) u_cb (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .run     (cfg_q[tio_pkg::CB_RUN_BIT]),
            .src_pin (cfg_q[tio_pkg::CB_SRC_BIT]),
            .pin_lvl (pin_in[tio_pkg::CLK_PIN]),
            .div     (cfg_q[tio_pkg::CB_DIV_W-1:0]),
            .tick    (cb_tick[c])
        );
    end

    // ------------------------------------------------------------
    // ports
    // ------------------------------------------------------------
    for (genvar i = 0; i < NP; i++) begin : g_port
        localparam int W   = tio_pkg::PORT_WIDTH[i];
        localparam int NSH = DW / W;

        logic [tio_pkg::CFG_W-1:0] cfg_q;
        logic [DW-1:0]             cond_q;
        logic [CW-1:0]             time_q;
        logic                      timed_q;
        logic [CW-1:0]             cnt_q;
        logic [CW-1:0]             ts_q;
        logic [DW-1:0]             sh_q;
        logic [5:0]                shn_q;
        logic [DW-1:0]             xfer_q;
        logic                      full_q;
        logic [W-1:0]              drv_q;
        logic                      ostb_q;
        logic                      ev_q;
        logic                      hit;
        logic                      tick;
        logic                      go;
        logic                      cond_ok;
        logic                      stb_ok;
        logic                      en;
        logic                      dir;
        logic                      load;
        logic                      in_step;
        logic                      in_done;
        logic [W-1:0]              pins;
        logic [DW-1:0]             sh_in;
        logic [DW-1:0]             sh_out;
        logic [2:0]                clk_sel;
        logic                      f_valid;
        logic [DW-1:0]             f_data;
        tio_pkg::tio_cond_t        cmode;

        assign hit     = accept && cpu_sel == 3'(i);
        assign en      = cfg_q[tio_pkg::CFG_EN_BIT];
        assign dir     = cfg_q[tio_pkg::CFG_DIR_BIT];
        assign clk_sel = cfg_q[tio_pkg::CFG_CLK_LSB +: 3];
        assign cmode   = tio_pkg::tio_cond_t'(cfg_q[tio_pkg::CFG_COND_LSB +: 2]);
        assign tick    = en && (clk_sel < 3'(NC)) && cb_tick[clk_sel];
        assign pins    = pin_in[W-1:0];
        assign go      = !timed_q || (cnt_q == time_q);
        assign stb_ok  = !cfg_q[tio_pkg::CFG_STB_BIT] || input_strobe[i];
        assign sh_in   = (sh_q >> W) | (DW'(pins) << (DW - W));
        assign sh_out  = sh_q >> W;

        always_comb begin
            case (cmode)
                tio_pkg::COND_EQ: cond_ok = (pins == cond_q[W-1:0]);
                tio_pkg::COND_NE: cond_ok = (pins != cond_q[W-1:0]);
                default:          cond_ok = 1'b1;
            endcase
        end

        // an input word starts only when timing, condition and strobe all agree; an output word waits on timing only
        assign load    = tick && dir && shn_q == '0 && f_valid && go;
        assign in_step = tick && !dir && stb_ok && (shn_q != '0 || (go && cond_ok));
        assign in_done = in_step && shn_q == 6'(NSH-1);

        tio_fifo #(
            .WIDTH (DW),
            .DEPTH (tio_pkg::FIFO_DEPTH)
        ) u_fifo (
            .sys_clk   (sys_clk),
            .rst_n     (rst_n),
            .in_valid  (cpu_req && cpu_op == tio_pkg::OP_OUT && cpu_sel == 3'(i)),
            .in_ready  (p_fifo_rdy[i]),
            .in_data   (cpu_wdata),
            .out_valid (f_valid),
            .out_ready (load),
            .out_data  (f_data)
        );

        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                cfg_q  <= tio_pkg::PORT_CFG_RST;
                cond_q <= 32'h0000_0000;
            end else if (hit && cpu_op == tio_pkg::OP_SETC) begin
                cfg_q <= cpu_wdata[tio_pkg::CFG_W-1:0];
            end else if (hit && cpu_op == tio_pkg::OP_SETD) begin
                cond_q <= cpu_wdata;
            end
        end

        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                cnt_q <= 16'h0000;
            end else if (tick) begin
                cnt_q <= cnt_q + 16'h0001;
            end
        end

        // a fresh request wins over the clear from a starting transfer
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                timed_q <= 1'b0;
                time_q  <= 16'h0000;
            end else if (hit && cpu_op == tio_pkg::OP_SETPT) begin
                timed_q <= 1'b1;
                time_q  <= cpu_wdata[CW-1:0];
            end else if (load || (in_step && shn_q == '0)) begin
                timed_q <= 1'b0;
            end
        end

        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                sh_q   <= 32'h0000_0000;
                shn_q  <= 6'h00;
                drv_q  <= '0;
                ostb_q <= 1'b0;
            end else if (load) begin
                sh_q   <= f_data;
                drv_q  <= f_data[W-1:0];
                shn_q  <= 6'(NSH-1);
                ostb_q <= 1'b1;
            end else if (tick && dir && shn_q != '0) begin
                sh_q   <= sh_out;
                drv_q  <= sh_out[W-1:0];
                shn_q  <= shn_q - 6'h01;
                ostb_q <= 1'b1;
            end else if (tick && dir) begin
                ostb_q <= 1'b0;
            end else if (in_step) begin
                sh_q   <= sh_in;
                shn_q  <= in_done ? 6'h00 : shn_q + 6'h01;
                ostb_q <= 1'b0;
            end else if (!dir) begin
                ostb_q <= 1'b0;
            end
        end

        // completing word sets full even when the processor reads it now
        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                xfer_q <= 32'h0000_0000;
                full_q <= 1'b0;
            end else if (in_done) begin
                xfer_q <= sh_in;
                full_q <= 1'b1;
            end else if (hit && cpu_op == tio_pkg::OP_IN) begin
                full_q <= 1'b0;
            end
        end

        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                ts_q <= 16'h0000;
            end else if (load || in_done) begin
                ts_q <= cnt_q;
            end
        end

        always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
                ev_q <= 1'b0;
            end else begin
                ev_q <= tick && !dir && shn_q == '0 && cmode != tio_pkg::COND_NONE
                        && cond_ok && go;
            end
        end

        assign p_drv[i]         = DW'(drv_q);
        assign p_xfer[i]        = xfer_q;
        assign p_cnt[i]         = cnt_q;
        assign p_ts[i]          = ts_q;
        assign p_en[i]          = en;
        assign p_od[i]          = cfg_q[tio_pkg::CFG_OD_BIT];
        assign p_dir[i]         = dir;
        assign p_full[i]        = full_q;
        assign output_strobe[i] = ostb_q && cfg_q[tio_pkg::CFG_STB_BIT];
        assign sched_event[i]   = ev_q;
    end

    // ------------------------------------------------------------
    // pin ownership and drive
    // ------------------------------------------------------------
    // ports are ordered narrowest first, so the first claimant wins
    always_comb begin
        logic found;
        found      = 1'b0;
        pin_out_d  = 32'h0000_0000;
        pin_oe_n_d = 32'hffff_ffff;
        for (int p = 0; p < 32; p++) begin
            found = 1'b0;
            for (int i = 0; i < NP; i++) begin
                if (!found && p_en[i] && p < tio_pkg::PORT_WIDTH[i]) begin
                    found = 1'b1;
                    if (p_dir[i] && !link_pin_en[p]) begin
                        if (p_od[i]) begin
                            pin_out_d[p]  = 1'b0;
                            pin_oe_n_d[p] = p_drv[i][p];
                        end else begin
                            pin_out_d[p]  = p_drv[i][p];
                            pin_oe_n_d[p] = 1'b0;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out  <= 32'h0000_0000;
            pin_oe_n <= 32'hffff_ffff;
        end else begin
            pin_out  <= pin_out_d;
            pin_oe_n <= pin_oe_n_d;
        end
    end

    // pull-downs held on through reset, released on the first edge after
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_pd <= 32'hffff_ffff;
        end else begin
            pin_pd <= 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // read answers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata  <= 32'h0000_0000;
            cpu_rvalid <= 1'b0;
        end else begin
            cpu_rvalid <= 1'b0;
            if (accept && sel_port) begin
                case (cpu_op)
                    tio_pkg::OP_IN: begin
                        cpu_rdata  <= p_xfer[cpu_sel];
                        cpu_rvalid <= 1'b1;
                    end
                    tio_pkg::OP_GETTS: begin
                        cpu_rdata  <= {16'h0000, p_ts[cpu_sel]};
                        cpu_rvalid <= 1'b1;
                    end
                    tio_pkg::OP_GETCNT: begin
                        cpu_rdata  <= {16'h0000, p_cnt[cpu_sel]};
                        cpu_rvalid <= 1'b1;
                    end
                    default: begin
                        cpu_rdata <= cpu_rdata;
                    end
                endcase
            end
        end
    end
endmodule // tio_port_bank

// ---- tio_port_bank_assertions.sv ----
// concurrent checks on the port bank's processor and pin ports
module tio_port_bank_assertions (
    input wire logic             sys_clk,
    input wire logic             rst_n,
    input wire logic             cpu_req,
    input wire tio_pkg::tio_op_t cpu_op,
    input wire logic [2:0]       cpu_sel,
    input wire logic             cpu_ready,
    input wire logic [31:0]      cpu_rdata,
    input wire logic             cpu_rvalid,
    input wire logic [31:0]      link_pin_en,
    input wire logic [31:0]      pin_oe_n,
    input wire logic [31:0]      pin_pd
);
    // ----
    // properties
    // ----
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence s_take;
        cpu_req && cpu_ready;
    endsequence
    sequence s_rd;
        s_take ##0 (cpu_sel < 3'h5 &&
            cpu_op inside {tio_pkg::OP_IN, tio_pkg::OP_GETTS, tio_pkg::OP_GETCNT});
    endsequence
    sequence s_wr;
        s_take ##0 !(cpu_op inside {tio_pkg::OP_IN, tio_pkg::OP_GETTS, tio_pkg::OP_GETCNT});
    endsequence
    a_read_answer: assert property (s_rd |=> cpu_rvalid)
        else $error("read not answered next cycle");
    a_write_silent: assert property (s_wr |=> !cpu_rvalid)
        else $error("answer after a write");
    a_ready_always: assert property (cpu_req && !(cpu_op inside {tio_pkg::OP_OUT,
        tio_pkg::OP_IN}) |-> cpu_ready) else $error("access refused");
    a_rdata_hold: assert property (!cpu_rvalid |-> $stable(cpu_rdata))
        else $error("read data moved");
    a_count_upper: assert property (cpu_rvalid && $past(cpu_op) inside
        {tio_pkg::OP_GETTS, tio_pkg::OP_GETCNT} |-> cpu_rdata[31:16] == 16'h0000)
        else $error("count upper half set");
    a_pd_reset: assert property ($rose(rst_n) |-> $past(pin_pd) == '1
        && $past(pin_oe_n) == '1) else $error("pins not parked in reset");
    a_pd_release: assert property ($past(rst_n) |-> pin_pd == 32'h0000_0000)
        else $error("pull-down after reset");
    // link must hold three samples, though only the pin flop adds a cycle after the link mask
    a_link_release: assert property (&(pin_oe_n | ~(link_pin_en &
        $past(link_pin_en) & $past(link_pin_en, 2)))) else $error("link pin driven");
endmodule // tio_port_bank_assertions

bind tio_port_bank tio_port_bank_assertions u_chk (.sys_clk, .rst_n, .cpu_req, .cpu_op,
    .cpu_sel, .cpu_ready, .cpu_rdata, .cpu_rvalid, .link_pin_en, .pin_oe_n, .pin_pd);

// ---- tio_port_bank_tb.sv ----
// self-checking bench for the timed i/o port bank
module tio_port_bank_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // harness
    // ----
    logic             sys_clk = 1'b0;
    logic             rst_n = 1'b0;
    logic             cpu_req = 1'b0;
    tio_pkg::tio_op_t cpu_op = tio_pkg::OP_OUT;
    logic [2:0]       cpu_sel = 3'h0;
    logic [31:0]      cpu_wdata = 32'h0;
    logic [31:0]      link_pin_en = 32'h0;
    logic [31:0]      ext_drv = 32'h0;
    logic [31:0]      ext_val = 32'h0;
    logic [4:0]       ext_stb = 5'h00;
    logic             cpu_ready, cpu_rvalid;
    logic [31:0]      cpu_rdata, pin_in, pin_out, pin_oe_n, pin_pd, got, cnt;
    logic [4:0]       input_strobe, output_strobe, sched_event;
    int               error_cnt = 0, n_tests = 0, cyc = 0, waited = 0;
    always #10 sys_clk = ~sys_clk;
    tio_port_bank u_dut (.sys_clk, .rst_n, .cpu_req, .cpu_op, .cpu_sel, .cpu_wdata, .cpu_ready,
        .cpu_rdata, .cpu_rvalid, .link_pin_en, .pin_in, .pin_out, .pin_oe_n, .pin_pd,
        .input_strobe, .output_strobe, .sched_event);
    tio_pin_model u_ext (.pin_out, .pin_oe_n, .pin_pd, .ext_drv, .ext_val, .ext_stb,
        .pin_in, .input_strobe);
    task automatic results();
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #2;
    endtask
    // held until an edge sees ready; ends one idle cycle after the answer
    task automatic acc(input tio_pkg::tio_op_t op, input logic [2:0] sel, input logic [31:0] wd);
        cpu_req = 1'b1;
        cpu_op = op;
        cpu_sel = sel;
        cpu_wdata = wd;
        waited = 0;
        @(negedge sys_clk);
        while (cpu_ready !== 1'b1) begin
            @(negedge sys_clk);
            waited++;
        end
        idle(1);
        cpu_req = 1'b0;
        got = cpu_rdata;
        idle(1);
    endtask
    // ----
    // tests
    // ----
    initial begin
        idle(20);
        cmp(pin_pd, 32'hffffffff);
        rst_n = 1'b1;
        idle(2);
        cmp(pin_pd, 32'h0);
        acc(tio_pkg::OP_SETC, 3'h4, 32'h005);
        acc(tio_pkg::OP_OUT, 3'h4, 32'h12345678);
        idle(4);
        cmp(pin_out, 32'h12345678);
        acc(tio_pkg::OP_SETC, 3'h4, 32'h007);
        link_pin_en = 32'h000f0000;
        acc(tio_pkg::OP_OUT, 3'h4, 32'h0000ffff);
        idle(4);
        cmp(pin_oe_n, 32'h000fffff);
        cmp(pin_out, 32'h0);
        link_pin_en = 32'h0;
        acc(tio_pkg::OP_SETC, 3'h4, 32'h005);
        acc(tio_pkg::OP_OUT, 3'h4, 32'hffffffff);
        acc(tio_pkg::OP_SETC, 3'h1, 32'h005);
        acc(tio_pkg::OP_OUT, 3'h1, 32'h0);
        idle(12);
        cmp(pin_out, 32'hfffffff0);
        acc(tio_pkg::OP_GETCNT, 3'h4, 32'h0);
        cnt = got;
        acc(tio_pkg::OP_SETPT, 3'h4, cnt + 32'd30);
        acc(tio_pkg::OP_OUT, 3'h4, 32'h5a5a5a5a);
        idle(10);
        cmp(pin_out, 32'hfffffff0);
        idle(30);
        cmp(pin_out, 32'h5a5a5a50);
        acc(tio_pkg::OP_GETTS, 3'h4, 32'h0);
        cmp(got, (cnt + 32'd30) & 32'hffff);
        acc(tio_pkg::OP_SETCB, 3'h0, 32'h0ff);
        acc(tio_pkg::OP_GETCNT, 3'h4, 32'h0);
        cnt = got;
        acc(tio_pkg::OP_GETCNT, 3'h4, 32'h0);
        cmp(got, (cnt + 32'd2) & 32'hffff);
        // 1-pin port needs 32 ticks a word, so the sixth push must wait
        acc(tio_pkg::OP_SETC, 3'h0, 32'h005);
        repeat (6) acc(tio_pkg::OP_OUT, 3'h0, 32'h0);
        cmp({31'h0, waited > 0}, 32'h1);
        for (int i = 0; i < 5; i++) acc(tio_pkg::OP_SETC, 3'(i), 32'h0);
        ext_drv = 32'h000000ff;
        ext_val = 32'h000000a5;
        acc(tio_pkg::OP_SETD, 3'h2, 32'h000000a5);
        acc(tio_pkg::OP_SETC, 3'h2, 32'h011);
        waited = 0;
        while (sched_event[2] !== 1'b1 && waited < 20) begin
            idle(1);
            waited++;
        end
        cmp({31'h0, sched_event[2]}, 32'h1);
        acc(tio_pkg::OP_IN, 3'h2, 32'h0);
        cmp(got, 32'ha5a5a5a5);
        acc(tio_pkg::OP_SETCB, 3'h1, 32'h302);
        acc(tio_pkg::OP_SETC, 3'h3, 32'h041);
        acc(tio_pkg::OP_GETCNT, 3'h3, 32'h0);
        cnt = got;
        ext_drv = 32'h1;
        repeat (8) begin
            ext_val = 32'h0;
            idle(2);
            ext_val = 32'h1;
            idle(2);
        end
        acc(tio_pkg::OP_GETCNT, 3'h3, 32'h0);
        cmp(got, (cnt + 32'd4) & 32'hffff);
        // strobed output: strobe stands only in the cycle after the load
        acc(tio_pkg::OP_SETC, 3'h4, 32'h00d);
        acc(tio_pkg::OP_OUT, 3'h4, 32'h000000c3);
        cmp({27'h0, output_strobe}, 32'h10);
        idle(1);
        cmp({27'h0, output_strobe}, 32'h0);
        // strobed input: no word completes while the far side holds strobe low
        ext_drv = 32'h000000ff;
        ext_val = 32'h0000003c;
        acc(tio_pkg::OP_SETC, 3'h2, 32'h009);
        acc(tio_pkg::OP_IN, 3'h2, 32'h0);
        idle(8);
        cmp({31'h0, cpu_ready}, 32'h0);
        ext_stb = 5'h04;
        idle(8);
        ext_stb = 5'h00;
        acc(tio_pkg::OP_IN, 3'h2, 32'h0);
        cmp(got, 32'h3c3c3c3c);
        results();
    end
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            results();
        end
    end
endmodule // tio_port_bank_tb
